//--- compare_jump_repeat_sequencer.sv
`timescale 1ns/1ps
// Function
// (RQ1) Compare skips when operand is less than or equal to register.
// (RQ2) Compare skips when operand strictly exceeds register.
// (RQ3) In-range skip: operand at most Q and above A.
// (RQ4) Out-of-range skip: operand above Q or at most A.
// (RQ5) Order: positive above +0, +0 above -0, -0 above negative.
// (RQ6) Masked compare tests A minus (Q AND operand).
// (RQ7) Masked compare leaves every operational register unchanged.
// (RQ8) Jump without code always taken; with code only when met.
// (RQ9) Jump target from accumulator uses its 15 low bits only.
// (RQ10) Taken return jump continues at target plus one.
// (RQ11) Taken return jump stores next address in target's low half.
// (RQ12) Repeat loads 15-bit count into index 7, repeats next.
// (RQ13) Zero repeat count skips the following instruction.
// (RQ14) Address changes under repeat live in transient registers only.
// (RQ15) Each repeated execution decrements index register 7.
// (RQ16) Advance mode steps address up, retreat mode steps down.
// (RQ17) Cumulative mode adds named index register to address each time.
// (RQ18) Replace-offset mode adds index 6 to store address only.
// (RQ19) Advance and retreat replace modes offset store, then step.
// (RQ20) Cumulative replace mode adds index cumulatively, offsets store.
// (RQ21) Index skip on equality skips and clears the register.
// (RQ22) Index skip on inequality continues and increments the register.
// (RQ23) Index jump continues at zero, else decrements and jumps.
// (RQ24) Index instructions use the three-bit designator as register.
// (RQ25) Repeat ends at zero count or skip, resuming after.
// (RQ26) All arithmetic is 30-bit ones-complement with sign on top; address and index sums here are plain 15-bit binary.
module compare_jump_repeat_sequencer (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Wishbone slave
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [7:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatWr,
  output logic [31:0] wbDatRd,
  output logic wbAck
);
  // ==========================================================
  // Helper functions
  function automatic logic [31:0] mergeSel(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : mergeSel

  function automatic logic isIndex(input logic [7:0] adr);
    return adr[7:5] == seq_pkg::INDEX_OFF[7:5];
  endfunction : isIndex

  // (RQ5) signed order key
  function automatic logic [29:0] keyOf(input logic [29:0] x);
    return {~x[29], x[28:0]};
  endfunction : keyOf

  // (RQ26) ones-complement zero test
  function automatic logic ocZero(input logic [29:0] x);
    return (x == 30'h0) || (x == 30'h3fffffff);
  endfunction : ocZero

  function automatic logic normCond(input logic [2:0] j,
      input logic [29:0] a, input logic [29:0] q);
    logic r;
    r = 1'b0;
    case (j)
      3'h1: r = 1'b1;
      3'h2: r = ~q[29];
      3'h3: r = q[29];
      3'h4: r = ocZero(a);
      3'h5: r = ~ocZero(a);
      3'h6: r = ~a[29];
      3'h7: r = a[29];
      default: r = 1'b0;
    endcase
    return r;
  endfunction : normCond

  // ==========================================================
  // State
  logic [29:0] instr_r, operand_r, acc_r, q_r, retWord_r;
  logic [14:0] pc_r, tAddr_r, effAddr_r, stAddr_r;
  logic [14:0] indexReg_r [seq_pkg::NUM_INDEX];
  logic [2:0] mode_r;
  logic repActive_r, repFresh_r, skip_r, jumped_r, storeValid_r;
  logic ack_r;
  logic [31:0] rdData_r;

  // ==========================================================
  // Bus decode
  logic wbHit, wbWrite, execGo;
  logic [31:0] curWord, wrWord;
  logic [2:0] wrIdx;

  assign wbHit = wbCyc && wbStb && !ack_r;
  assign wbWrite = wbHit && wbWe;
  assign wrIdx = wbAdr[4:2];
  assign execGo = wbWrite && wbAdr[7:2] == seq_pkg::CTRL_OFF[7:2]
    && wbSel[0] && wbDatWr[0];
  assign wrWord = mergeSel(curWord, wbDatWr, wbSel);
  assign wbAck = ack_r;
  assign wbDatRd = rdData_r;

  always_comb begin
    curWord = 32'h0;
    if (isIndex(wbAdr)) begin
      curWord = {17'h0, indexReg_r[wrIdx]};
    end else begin
      case (wbAdr)
        seq_pkg::INSTR_OFF: curWord = {2'h0, instr_r};
        seq_pkg::OPERAND_OFF: curWord = {2'h0, operand_r};
        seq_pkg::ACC_OFF: curWord = {2'h0, acc_r};
        seq_pkg::QREG_OFF: curWord = {2'h0, q_r};
        seq_pkg::PC_OFF: curWord = {17'h0, pc_r};
        seq_pkg::STATUS_OFF: curWord = {28'h0, storeValid_r,
          repActive_r, jumped_r, skip_r};
        seq_pkg::RETWORD_OFF: curWord = {2'h0, retWord_r};
        seq_pkg::EFFADDR_OFF: curWord = {17'h0, effAddr_r};
        seq_pkg::STOREADDR_OFF: curWord = {17'h0, stAddr_r};
        default: curWord = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ack_r <= 1'b0;
      rdData_r <= 32'h0;
    end else begin
      ack_r <= wbHit;
      rdData_r <= wbHit ? curWord : 32'h0;
    end
  end

  // ==========================================================
  // Instruction decode
  logic [5:0] fCode;
  logic [2:0] jCode, bDes;
  logic [14:0] yAddr, idxVal, b7Dec, count;
  logic [29:0] yKey, aKey, qKey, maskDiff;

  assign fCode = instr_r[seq_pkg::F_LSB +: 6];
  assign jCode = instr_r[seq_pkg::J_LSB +: 3];
  assign bDes = instr_r[seq_pkg::B_LSB +: 3];
  assign yAddr = instr_r[14:0];
  // (RQ24) designator picks the index register
  assign idxVal = indexReg_r[jCode];
  assign count = operand_r[14:0];
  assign b7Dec = indexReg_r[seq_pkg::COUNT_INDEX] - seq_pkg::ADDR_STEP;
  assign yKey = keyOf(operand_r);
  assign aKey = keyOf(acc_r);
  assign qKey = keyOf(q_r);

  // (RQ6) A minus the masked operand
  oc_adder #(.W(seq_pkg::WORD_W)) maskSub (
    .a(acc_r),
    .b(~(q_r & operand_r)),
    .sum(maskDiff)
  );

  // ==========================================================
  // Execution outcome
  logic skip, jump, cmpSkip, isRjp, repStep, repEnd;
  logic [14:0] base, effAddr, storeAddr, stepAddr, target, pcNext;

  assign isRjp = fCode == seq_pkg::RETURN_JUMP_OP;
  assign repStep = execGo && repActive_r
    && fCode != seq_pkg::REPEAT_OP;
  // (RQ25) count exhausted, skip or jump ends the repeat
  assign repEnd = repStep && (b7Dec == seq_pkg::ADDR_ZERO
    || skip || jump);

  always_comb begin
    cmpSkip = 1'b0;
    case (jCode)
      seq_pkg::ALWAYS_CODE: cmpSkip = 1'b1;
      // (RQ1) less or equal skip
      seq_pkg::OPERAND_LE_SKIP_Q: cmpSkip = yKey <= qKey;
      seq_pkg::OPERAND_LE_SKIP_A: cmpSkip = yKey <= aKey;
      // (RQ2) greater than skip
      seq_pkg::OPERAND_GT_SKIP_Q: cmpSkip = yKey > qKey;
      seq_pkg::OPERAND_GT_SKIP_A: cmpSkip = yKey > aKey;
      // (RQ3) in range
      seq_pkg::IN_RANGE_SKIP: cmpSkip = yKey <= qKey && yKey > aKey;
      // (RQ4) out of range
      seq_pkg::OUT_OF_RANGE_SKIP:
        cmpSkip = yKey > qKey || yKey <= aKey;
      default: cmpSkip = 1'b0;
    endcase
  end

  always_comb begin
    base = yAddr;
    // (RQ14) later passes take the transient address
    if (repActive_r && !repFresh_r) begin
      base = tAddr_r;
    end
    effAddr = base;
    // (RQ17) cumulative index addition
    // (RQ20) cumulative replace too
    if (repActive_r && (mode_r == seq_pkg::CUMULATIVE_INDEX_MODE
        || mode_r == seq_pkg::CUMULATIVE_INDEX_REPLACE_MODE)) begin
      effAddr = base + indexReg_r[bDes];
    end
    storeAddr = effAddr;
    // (RQ18) store half offset by index 6
    if (repActive_r && mode_r[2]) begin
      storeAddr = effAddr + indexReg_r[seq_pkg::REPLACE_INDEX];
    end
    stepAddr = effAddr;
    case (mode_r)
      // (RQ16) advance and retreat stepping
      seq_pkg::ADVANCE_MODE,
      seq_pkg::ADVANCE_REPLACE_MODE:
        stepAddr = effAddr + seq_pkg::ADDR_STEP;
      // (RQ19) replace variants step after offset
      seq_pkg::RETREAT_MODE,
      seq_pkg::RETREAT_REPLACE_MODE:
        stepAddr = effAddr - seq_pkg::ADDR_STEP;
      default: stepAddr = effAddr;
    endcase
    // (RQ9) accumulator target uses low 15 bits
    target = instr_r[seq_pkg::TGT_ACC_BIT] ? acc_r[14:0] : effAddr;
  end

  always_comb begin
    skip = 1'b0;
    jump = 1'b0;
    case (fCode)
      seq_pkg::COMPARE_OP: skip = cmpSkip;
      // (RQ6) condition on the difference
      seq_pkg::MASK_COMPARE_OP: skip = normCond(jCode, maskDiff, q_r);
      // (RQ8) unconditional or conditional transfer
      seq_pkg::JUMP_OP,
      seq_pkg::RETURN_JUMP_OP:
        jump = jCode == 3'h0 || normCond(jCode, acc_r, q_r);
      // (RQ21) equality skips
      seq_pkg::INDEX_SKIP_OP: skip = idxVal == count;
      // (RQ23) nonzero register jumps
      seq_pkg::INDEX_JUMP_OP: jump = idxVal != seq_pkg::ADDR_ZERO;
      // (RQ13) zero count skips
      seq_pkg::REPEAT_OP: skip = count == seq_pkg::ADDR_ZERO;
      default: skip = 1'b0;
    endcase
  end

  always_comb begin
    pcNext = pc_r + seq_pkg::ADDR_STEP;
    if (jump) begin
      // (RQ10) return jump lands one past target
      pcNext = isRjp ? target + seq_pkg::ADDR_STEP : target;
    end else if (repStep && !repEnd) begin
      pcNext = pc_r;
    end else if (fCode == seq_pkg::REPEAT_OP
        && count == seq_pkg::ADDR_ZERO) begin
      // (RQ13) zero count skips the next one
      pcNext = pc_r + 15'h2;
    end else if (skip) begin
      pcNext = pc_r + 15'h2;
    end
  end

  // ==========================================================
  // Software-owned operational registers
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      instr_r <= seq_pkg::WORD_RST;
      operand_r <= seq_pkg::WORD_RST;
      acc_r <= seq_pkg::WORD_RST;
      q_r <= seq_pkg::WORD_RST;
    end else if (wbWrite) begin
      // (RQ7) only the bus changes A and Q
      case (wbAdr)
        seq_pkg::INSTR_OFF: instr_r <= wrWord[29:0];
        seq_pkg::OPERAND_OFF: operand_r <= wrWord[29:0];
        seq_pkg::ACC_OFF: acc_r <= wrWord[29:0];
        seq_pkg::QREG_OFF: q_r <= wrWord[29:0];
        default: instr_r <= instr_r;
      endcase
    end
  end

  // ==========================================================
  // Program counter and outcome status
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pc_r <= seq_pkg::ADDR_RST;
      skip_r <= 1'b0;
      jumped_r <= 1'b0;
      storeValid_r <= 1'b0;
      retWord_r <= seq_pkg::WORD_RST;
      effAddr_r <= seq_pkg::ADDR_RST;
      stAddr_r <= seq_pkg::ADDR_RST;
    end else if (execGo) begin
      pc_r <= pcNext;
      skip_r <= skip;
      jumped_r <= jump;
      effAddr_r <= effAddr;
      stAddr_r <= (isRjp && jump) ? target : storeAddr;
      storeValid_r <= isRjp && jump;
      if (isRjp && jump) begin
        // (RQ11) return address into low half
        retWord_r <= {15'h0, pc_r + seq_pkg::ADDR_STEP};
      end
    end else if (wbWrite && wbAdr == seq_pkg::PC_OFF) begin
      pc_r <= wrWord[14:0];
    end
  end

  // ==========================================================
  // Index registers
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < seq_pkg::NUM_INDEX; i++) begin
        indexReg_r[i] <= seq_pkg::ADDR_RST;
      end
    end else if (execGo) begin
      case (fCode)
        // (RQ22) mismatch increments, match clears
        seq_pkg::INDEX_SKIP_OP:
          indexReg_r[jCode] <= skip ? seq_pkg::ADDR_ZERO
            : idxVal + seq_pkg::ADDR_STEP;
        seq_pkg::INDEX_JUMP_OP:
          if (jump) begin
            indexReg_r[jCode] <= idxVal - seq_pkg::ADDR_STEP;
          end
        // (RQ12) count into index register 7
        seq_pkg::REPEAT_OP:
          indexReg_r[seq_pkg::COUNT_INDEX] <= count;
        default: ;
      endcase
      // (RQ15) one less per repeated pass
      if (repStep) begin
        indexReg_r[seq_pkg::COUNT_INDEX] <= b7Dec;
      end
    end else if (wbWrite && isIndex(wbAdr)) begin
      indexReg_r[wrIdx] <= wrWord[14:0];
    end
  end

  // ==========================================================
  // Repeat sequencing
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      repActive_r <= 1'b0;
      repFresh_r <= 1'b0;
      mode_r <= 3'h0;
      tAddr_r <= seq_pkg::ADDR_RST;
    end else if (execGo) begin
      if (fCode == seq_pkg::REPEAT_OP) begin
        repActive_r <= count != seq_pkg::ADDR_ZERO;
        repFresh_r <= 1'b1;
        mode_r <= jCode;
      end else if (repStep) begin
        // (RQ25) end or keep going
        repActive_r <= !repEnd;
        repFresh_r <= 1'b0;
        // (RQ14) stepped address kept aside
        tAddr_r <= stepAddr;
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  a_le_skip: assert property (execGo && fCode == seq_pkg::COMPARE_OP // (RQ1)
    && jCode == seq_pkg::OPERAND_LE_SKIP_Q && yKey <= qKey
    |=> skip_r && wbAck) else $error("le skip missed");
  a_gt_skip: assert property (execGo && fCode == seq_pkg::COMPARE_OP // (RQ2)
    && jCode == seq_pkg::OPERAND_GT_SKIP_A && yKey > aKey && !repActive_r
    |=> skip_r && pc_r == $past(pc_r) + 15'h2) else $error("gt skip");
  a_mask_keep: assert property (execGo // (RQ7)
    && fCode == seq_pkg::MASK_COMPARE_OP
    |=> acc_r == $past(acc_r) && q_r == $past(q_r))
    else $error("mask changed register");
  a_jump_seq: assert property (execGo && fCode == seq_pkg::JUMP_OP // (RQ8)
    && !jump && !repActive_r |=> pc_r == $past(pc_r) + 15'h1)
    else $error("untaken jump moved");
  a_rjp_store: assert property (execGo && isRjp && jump // (RQ11)
    |=> storeValid_r && retWord_r[14:0] == $past(pc_r) + 15'h1
    && pc_r == stAddr_r + 15'h1) else $error("return jump wrong");
  a_rpt_zero: assert property (execGo // (RQ13)
    && fCode == seq_pkg::REPEAT_OP && count == 15'h0
    |=> !repActive_r && pc_r == $past(pc_r) + 15'h2)
    else $error("zero repeat not skipped");
  a_rpt_count: assert property (repStep // (RQ15)
    && fCode != seq_pkg::INDEX_SKIP_OP && fCode != seq_pkg::INDEX_JUMP_OP
    |=> indexReg_r[7] == $past(indexReg_r[7]) - 15'h1)
    else $error("count not decremented");
  a_rpt_end: assert property (repStep && b7Dec == 15'h0 // (RQ25)
    |=> !repActive_r ##1 !repActive_r || $past(execGo))
    else $error("repeat did not end");
  a_bsk_clear: assert property (execGo // (RQ21)
    && fCode == seq_pkg::INDEX_SKIP_OP && idxVal == count && jCode != 3'h7
    |=> indexReg_r[$past(jCode)] == 15'h0 && skip_r)
    else $error("index skip not cleared");
  a_bjp_jump: assert property (execGo // (RQ23)
    && fCode == seq_pkg::INDEX_JUMP_OP && idxVal != 15'h0
    |=> jumped_r && pc_r == effAddr_r) else $error("index jump");

  c_repeat_run: cover property (repStep ##[1:20] repStep && repEnd);
  c_rjp: cover property (execGo && isRjp && jump);
  c_range: cover property (execGo && fCode == seq_pkg::COMPARE_OP
    && jCode == seq_pkg::IN_RANGE_SKIP && cmpSkip);
endmodule : compare_jump_repeat_sequencer

//--- oc_adder.sv
`timescale 1ns/1ps
// Ones-complement adder with end-around carry
module oc_adder #(
  parameter int W = 30
) (
  // Operands
  input wire logic [W-1:0] a,
  input wire logic [W-1:0] b,
  // Result
  output logic [W-1:0] sum
);
  logic [W:0] raw;

  assign raw = {1'b0, a} + {1'b0, b};
  assign sum = raw[W-1:0] + {{(W-1){1'b0}}, raw[W]};
endmodule : oc_adder

//--- seq_pkg.sv
package seq_pkg;
  // ==========================================================
  // Word and field layout
  localparam int WORD_W = 30;
  localparam int ADDR_W = 15;
  localparam int NUM_INDEX = 8;
  localparam int F_LSB = 24;
  localparam int J_LSB = 21;
  localparam int TGT_ACC_BIT = 20;
  localparam int B_LSB = 15;
  localparam logic [2:0] REPLACE_INDEX = 3'h6;
  localparam logic [2:0] COUNT_INDEX = 3'h7;
  localparam logic [14:0] ADDR_STEP = 15'h1;
  localparam logic [14:0] ADDR_ZERO = 15'h0;

  // ==========================================================
  // Function codes
  localparam logic [5:0] COMPARE_OP = 6'h04;
  localparam logic [5:0] MASK_COMPARE_OP = 6'h23;
  localparam logic [5:0] JUMP_OP = 6'h30;
  localparam logic [5:0] RETURN_JUMP_OP = 6'h34;
  localparam logic [5:0] REPEAT_OP = 6'h38;
  localparam logic [5:0] INDEX_SKIP_OP = 6'h39;
  localparam logic [5:0] INDEX_JUMP_OP = 6'h3a;

  // ==========================================================
  // Designator codes
  localparam logic [2:0] ALWAYS_CODE = 3'h1;
  localparam logic [2:0] OPERAND_LE_SKIP_Q = 3'h2;
  localparam logic [2:0] OPERAND_GT_SKIP_Q = 3'h3;
  localparam logic [2:0] IN_RANGE_SKIP = 3'h4;
  localparam logic [2:0] OUT_OF_RANGE_SKIP = 3'h5;
  localparam logic [2:0] OPERAND_LE_SKIP_A = 3'h6;
  localparam logic [2:0] OPERAND_GT_SKIP_A = 3'h7;
  localparam logic [2:0] ADVANCE_MODE = 3'h1;
  localparam logic [2:0] RETREAT_MODE = 3'h2;
  localparam logic [2:0] CUMULATIVE_INDEX_MODE = 3'h3;
  localparam logic [2:0] ADVANCE_REPLACE_MODE = 3'h5;
  localparam logic [2:0] RETREAT_REPLACE_MODE = 3'h6;
  localparam logic [2:0] CUMULATIVE_INDEX_REPLACE_MODE = 3'h7;

  // ==========================================================
  // Register offsets, status bits, reset values
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] INSTR_OFF = 8'h04;
  localparam logic [7:0] OPERAND_OFF = 8'h08;
  localparam logic [7:0] ACC_OFF = 8'h0c;
  localparam logic [7:0] QREG_OFF = 8'h10;
  localparam logic [7:0] PC_OFF = 8'h14;
  localparam logic [7:0] STATUS_OFF = 8'h18;
  localparam logic [7:0] RETWORD_OFF = 8'h1c;
  localparam logic [7:0] EFFADDR_OFF = 8'h20;
  localparam logic [7:0] STOREADDR_OFF = 8'h24;
  localparam logic [7:0] INDEX_OFF = 8'h40;
  localparam int ST_SKIP = 0;
  localparam int ST_JUMP = 1;
  localparam int ST_REPEAT = 2;
  localparam int ST_STORE = 3;
  localparam logic [29:0] WORD_RST = 30'h0;
  localparam logic [14:0] ADDR_RST = 15'h0;
endpackage : seq_pkg

//--- tb.sv
`timescale 1ns/1ps
module tb;
  typedef struct {
    logic [31:0] expVal;
    logic [31:0] mask;
    string what;
  } note_t;
  localparam logic [29:0] JACC[5] = '{30'h1234, 30'h3fff5a5a, 30'h1,
    30'h3fffffff, 30'h3ffffff0};
  localparam logic [2:0] JCODE[5] = '{3'h0, 3'h0, 3'h4, 3'h4, 3'h6};
  localparam logic [4:0] JTAKE = 5'b01011;
  // ==========================================================
  // Ports and bookkeeping
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbWe = 1'b0;
  logic [7:0] wbAdr = 8'h00;
  logic [3:0] wbSel = 4'h0;
  logic [31:0] wbDatWr = 32'h0;
  logic [31:0] wbDatRd;
  logic wbAck;
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  note_t notes[$];
  note_t got;

  compare_jump_repeat_sequencer i_compare_jump_repeat_sequencer (
    .clock(clock), .nrst(nrst), .wbCyc(wbCyc), .wbStb(wbStb),
    .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatWr(wbDatWr),
    .wbDatRd(wbDatRd), .wbAck(wbAck));

  always #12.5 clock = ~clock;

  task automatic close_out;
    if (err_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] expVal);
    samples_checked++;
    if (seen !== expVal) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, expVal, seen);
    end
  endtask : chk

  // ==========================================================
  // Monitor takes the oldest note at each read answer
  always @(posedge clock) begin
    cycles++;
    if (cycles == 10000) begin
      err_count++;
      close_out();
    end
    if (wbAck === 1'b1 && wbWe === 1'b0 && notes.size() > 0) begin
      got = notes.pop_front();
      chk(got.what, wbDatRd & got.mask, got.expVal & got.mask);
    end
  end

  // ==========================================================
  // Bus cycles
  task automatic xfer(input logic we, input logic [7:0] adr,
                      input logic [31:0] dat, input logic [3:0] sel);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbDatWr <= dat;
    wbSel <= sel;
    @(posedge clock);
    while (wbAck !== 1'b1) begin
      @(posedge clock);
    end
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge clock);
  endtask : xfer

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    xfer(1'b1, adr, dat, 4'hf);
  endtask : wr

  task automatic rd(input string what, input logic [7:0] adr,
                    input logic [31:0] expVal, input logic [31:0] mask);
    notes.push_back('{expVal, mask, what});
    xfer(1'b0, adr, 32'h0, 4'hf);
  endtask : rd

  function automatic logic [7:0] bAdr(input int n);
    bAdr = seq_pkg::INDEX_OFF + 8'(4 * n);
  endfunction : bAdr

  task automatic chkPc(input logic [14:0] e);
    rd("pc", seq_pkg::PC_OFF, {17'h0, e}, 32'h7fff);
  endtask : chkPc

  task automatic chkSt(input logic [31:0] m, input logic [31:0] e);
    rd("status", seq_pkg::STATUS_OFF, e, m);
  endtask : chkSt

  task automatic chkB(input int n, input logic [14:0] e);
    rd("index", bAdr(n), {17'h0, e}, 32'h7fff);
  endtask : chkB

  task automatic setRegs(input logic [29:0] a, input logic [29:0] q,
                         input logic [14:0] pc);
    wr(seq_pkg::ACC_OFF, {2'b00, a});
    wr(seq_pkg::QREG_OFF, {2'b00, q});
    wr(seq_pkg::PC_OFF, {17'h0, pc});
  endtask : setRegs

  task automatic exec(input logic [29:0] ins, input logic [29:0] y);
    wr(seq_pkg::INSTR_OFF, {2'b00, ins});
    wr(seq_pkg::OPERAND_OFF, {2'b00, y});
    wr(seq_pkg::CTRL_OFF, 32'h1);
  endtask : exec

  function automatic logic [29:0] mk(input logic [5:0] f,
      input logic [2:0] j, input logic ta, input logic [2:0] b,
      input logic [14:0] y);
    mk = {f, j, ta, 2'b00, b, y};
  endfunction : mk

  // Ordering key: +n > +0 > -0 > -n
  function automatic longint key(input logic [29:0] v);
    if (v[29] == 1'b0) key = 2 * longint'(v) + 1;
    else key = -2 * longint'(v ^ 30'h3fffffff);
  endfunction : key

  function automatic logic [29:0] rv();
    logic [29:0] m;
    m = 30'($urandom_range(0, 3));
    case ($urandom_range(0, 2))
      0: rv = m;
      1: rv = ~m;
      default: rv = 30'($urandom);
    endcase
  endfunction : rv

  // ==========================================================
  // Main sequence
  initial begin
    logic [29:0] a;
    logic [29:0] q;
    logic [29:0] y;
    logic [29:0] ri;
    logic [14:0] d;
    logic sk;
    int j;
    int k;
    void'($urandom(41));
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    for (int n = 0; n < 8; n++) begin
      chkB(n, 15'h0);
    end
    chkSt(32'hffffffff, 32'h0);
    chkPc(15'h0);
    wr(8'hfc, 32'h5);
    rd("unmapped", 8'hfc, 32'h0, 32'hffffffff);
    wr(seq_pkg::ACC_OFF, 32'h12345678);
    xfer(1'b1, seq_pkg::ACC_OFF, 32'hffffffff, 4'h2);
    rd("acc", seq_pkg::ACC_OFF, 32'h1234ff78, 32'hffffffff);
    for (int i = 0; i < 48; i++) begin
      j = 2 + i % 6;
      a = rv();
      q = rv();
      y = rv();
      case (j)
        2: sk = key(y) <= key(q);
        3: sk = key(y) > key(q);
        4: sk = key(y) <= key(q) && key(y) > key(a);
        5: sk = key(y) > key(q) || key(y) <= key(a);
        6: sk = key(y) <= key(a);
        default: sk = key(y) > key(a);
      endcase
      setRegs(a, q, 15'h100);
      exec(mk(seq_pkg::COMPARE_OP, 3'(j), 1'b0, 3'h0, 15'h0), y);
      chkSt(32'h1, {31'h0, sk});
      chkPc(sk ? 15'h102 : 15'h101);
    end
    for (int i = 0; i < 8; i++) begin
      q = rv();
      y = rv();
      a = (i % 2 == 0) ? (q & y) : rv();
      sk = (a == (q & y)) || ({a, q & y} == {30'h0, 30'h3fffffff})
        || ({a, q & y} == {30'h3fffffff, 30'h0});
      sk = sk ^ (i >= 4);
      setRegs(a, q, 15'h100);
      exec(mk(seq_pkg::MASK_COMPARE_OP, i < 4 ? 3'h4 : 3'h5, 1'b0, 3'h0,
        15'h0), y);
      chkPc(sk ? 15'h102 : 15'h101);
      rd("acc", seq_pkg::ACC_OFF, {2'b00, a}, 32'hffffffff);
      rd("q", seq_pkg::QREG_OFF, {2'b00, q}, 32'hffffffff);
    end
    for (int r = 0; r < 10; r++) begin
      k = r % 5;
      d = (k == 1) ? 15'h5a5a : 15'h2345;
      setRegs(JACC[k], rv(), 15'h26e4);
      exec(mk(r < 5 ? seq_pkg::JUMP_OP : seq_pkg::RETURN_JUMP_OP, JCODE[k],
        k == 1, 3'h0, 15'h2345), 30'h0);
      if (r < 5) begin
        chkPc(JTAKE[k] ? d : 15'h26e5);
        chkSt(32'h2, {30'h0, JTAKE[k], 1'b0});
      end else begin
        chkPc(JTAKE[k] ? d + 15'h1 : 15'h26e5);
        chkSt(32'h8, {28'h0, JTAKE[k], 3'h0});
      end
      if (r >= 5 && JTAKE[k]) begin
        rd("retword", seq_pkg::RETWORD_OFF, 32'h26e5, 32'h7fff);
        rd("store", seq_pkg::STOREADDR_OFF, {17'h0, d}, 32'h7fff);
      end
    end
    for (int r = 0; r < 28; r++) begin
      j = 1 + r % 7;
      a = rv();
      q = rv();
      case (j)
        1: sk = 1'b1;
        2: sk = !q[29];
        3: sk = q[29];
        4: sk = a == 30'h0 || a == 30'h3fffffff;
        5: sk = !(a == 30'h0 || a == 30'h3fffffff);
        6: sk = !a[29];
        default: sk = a[29];
      endcase
      setRegs(a, q, 15'h700);
      exec(mk(seq_pkg::JUMP_OP, 3'(j), 1'b0, 3'h0, 15'h1234), 30'h0);
      chkPc(sk ? 15'h1234 : 15'h701);
    end
    wr(seq_pkg::PC_OFF, 32'h50);
    exec(mk(seq_pkg::REPEAT_OP, 3'h1, 1'b0, 3'h0, 15'h0), 30'h0);
    chkSt(32'h5, 32'h1);
    chkPc(15'h52);
    ri = mk(seq_pkg::COMPARE_OP, 3'h0, 1'b0, 3'h2, 15'h200);
    for (int m = 0; m < 8; m++) begin
      d = (m % 4 == 1) ? 15'h1 : (m % 4 == 2) ? 15'h7fff
        : (m % 4 == 3) ? 15'h5 : 15'h0;
      wr(bAdr(2), 32'h5);
      wr(bAdr(6), 32'h40);
      wr(seq_pkg::PC_OFF, 32'h60);
      exec(mk(seq_pkg::REPEAT_OP, 3'(m), 1'b0, 3'h0, 15'h0), 30'h2);
      chkPc(15'h61);
      chkB(7, 15'h2);
      chkSt(32'h4, 32'h4);
      for (int p = 0; p < 2; p++) begin
        if (p == 0) exec(ri, 30'h0);
        else wr(seq_pkg::CTRL_OFF, 32'h1);
        y = {15'h0, 15'h200 + (p == 1 ? d : 15'h0)
          + (m % 4 == 3 ? d : 15'h0)};
        rd("eff", seq_pkg::EFFADDR_OFF, {2'b00, y}, 32'h7fff);
        if (m >= 4) begin
          rd("store", seq_pkg::STOREADDR_OFF, {2'b00, y + 30'h40},
            32'h7fff);
        end
        chkB(7, p == 1 ? 15'h0 : 15'h1);
      end
      chkPc(15'h62);
      chkSt(32'h4, 32'h0);
      rd("instr", seq_pkg::INSTR_OFF, {2'b00, ri}, 32'hffffffff);
    end
    for (int n = 0; n < 8; n++) begin
      wr(bAdr(n), 32'(n + 3));
      exec(mk(seq_pkg::INDEX_SKIP_OP, 3'(n), 1'b0, 3'h0, 15'h0), 30'(n + 3));
      chkSt(32'h1, 32'h1);
      chkB(n, 15'h0);
      exec(mk(seq_pkg::INDEX_SKIP_OP, 3'(n), 1'b0, 3'h0, 15'h0), 30'h7);
      chkSt(32'h1, 32'h0);
      chkB(n, 15'h1);
      wr(seq_pkg::PC_OFF, 32'h300);
      for (int p = 0; p < 2; p++) begin
        exec(mk(seq_pkg::INDEX_JUMP_OP, 3'(n), 1'b0, 3'h0, 15'h1234),
          30'h1234);
        chkPc(p == 0 ? 15'h1234 : 15'h1235);
        chkB(n, 15'h0);
      end
    end
    repeat (3) @(posedge clock);
    if (notes.size() != 0) err_count++;
    close_out();
  end
endmodule : tb
